// *** rtl/pd_pkg.sv ***
package pd_pkg;
  // Register indices on the link
  localparam logic [1:0] ADDR_FIRST = 2'h0;
  localparam logic [1:0] ADDR_SECOND = 2'h1;
  localparam logic [1:0] ADDR_STOP_A = 2'h2;
  localparam logic [1:0] ADDR_STOP_B = 2'h3;
  // Writable bit masks, reserved bits stay zero
  localparam logic [7:0] FIRST_MASK = 8'h88;
  localparam logic [7:0] SECOND_MASK = 8'hc6;
  localparam logic [7:0] STOP_A_MASK = 8'h17;
  localparam logic [7:0] STOP_B_MASK = 8'h11;
  // Reset values
  localparam logic [7:0] FIRST_RESET = 8'h00;
  localparam logic [7:0] SECOND_RESET = 8'h00;
  localparam logic [7:0] STOP_A_RESET = 8'h00;
  localparam logic [7:0] STOP_B_RESET = 8'h00;
  // Field positions
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int DEBUG_STOP_BIT = 7;
  localparam int BREAK_STOP_BIT = 6;
  localparam int CACHE_STOP_BIT = 2;
  localparam int UMEM_STOP_BIT = 1;
  localparam int TIMER_STOP_BIT = 4;
  localparam int SERIAL2_STOP_BIT = 2;
  localparam int SERIAL1_STOP_BIT = 1;
  localparam int SERIAL0_STOP_BIT = 0;
  localparam int HOST_IF_STOP_BIT = 4;
  localparam int REDUNDANCY_STOP_BIT = 0;
  // Clock enable vector: index of each gated module
  localparam int NUM_MODULES = 10;
  localparam int MOD_TIMER = 0;
  localparam int MOD_SERIAL0 = 1;
  localparam int MOD_SERIAL1 = 2;
  localparam int MOD_SERIAL2 = 3;
  localparam int MOD_HOST_IF = 4;
  localparam int MOD_REDUNDANCY = 5;
  localparam int MOD_DEBUG = 6;
  localparam int MOD_BREAK = 7;
  localparam int MOD_CACHE = 8;
  localparam int MOD_UMEM = 9;
  // Watchdog settling and re-entry, low-level external sense code
  localparam logic [7:0] WDT_LAST = 8'hff;
  localparam logic [7:0] WDT_REARM = 8'h80;
  localparam int PRESCALE_WIDTH_DEF = 12;
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  // Avalon register byte offsets of the CPU side
  localparam logic [4:0] AV_REG_WRITE = 5'h00;
  localparam logic [4:0] AV_REG_READ = 5'h04;
  localparam logic [4:0] AV_SLEEP = 5'h08;
  localparam logic [4:0] AV_IRQ = 5'h0c;
  localparam logic [4:0] AV_CONFIG = 5'h10;
  localparam logic [4:0] AV_STATUS = 5'h14;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_SLEEP = 3'b001,
    MODE_STANDBY = 3'b010,
    MODE_SETTLE = 3'b011,
    MODE_LOCKED = 3'b100
  } mode_e;
endpackage : pd_pkg

// *** rtl/pd_link_if.sv ***
interface pd_link_if;
  // CPU side to controller
  logic reg_wr;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic sleep_exec;
  logic nmi;
  logic dbg_irq;
  logic ubc_irq;
  logic ext_irq;
  logic per_irq;
  logic [3:0] ext_prio;
  logic [3:0] per_prio;
  logic [3:0] sr_mask;
  logic [1:0] ext_sense;
  logic [2:0] wdt_cks;
  logic dbg_reset;
  // Controller to CPU side
  logic [7:0] reg_rdata;
  pd_pkg::mode_e mode;
  logic cpu_run;
  logic exc_start;
  logic resume;

  modport dev (
    input reg_wr, reg_addr, reg_wdata, sleep_exec, nmi, dbg_irq, ubc_irq, ext_irq,
    input per_irq, ext_prio, per_prio, sr_mask, ext_sense, wdt_cks, dbg_reset,
    output reg_rdata, mode, cpu_run, exc_start, resume
  );
  modport cpu (
    output reg_wr, reg_addr, reg_wdata, sleep_exec, nmi, dbg_irq, ubc_irq, ext_irq,
    output per_irq, ext_prio, per_prio, sr_mask, ext_sense, wdt_cks, dbg_reset,
    input reg_rdata, mode, cpu_run, exc_start, resume
  );
endinterface : pd_link_if

// *** rtl/cpu_side_agent.sv ***
module cpu_side_agent (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link to the controller
  pd_link_if.cpu link
);
  logic req;
  logic seen;
  logic take;
  logic [31:0] config_word;
  logic exc_seen;
  logic resume_seen;

  assign req = avs_read || avs_write;
  assign seen = req && avs_waitrequest;
  // Writes land where waitrequest is low
  assign take = req && !avs_waitrequest;

  // One wait cycle, then the answer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !seen;
    end
  end

  // Link register access
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.reg_wr <= 1'b0;
      link.reg_addr <= 2'h0;
      link.reg_wdata <= 8'h00;
    end else begin
      link.reg_wr <= take && avs_write && avs_address == pd_pkg::AV_REG_WRITE;
      if (take && avs_write && (avs_address == pd_pkg::AV_REG_WRITE ||
          avs_address == pd_pkg::AV_REG_READ)) begin
        link.reg_addr <= avs_writedata[9:8];
        link.reg_wdata <= avs_writedata[7:0];
      end
    end
  end

  // Event pulses and priorities
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.sleep_exec <= 1'b0;
      link.nmi <= 1'b0;
      link.dbg_irq <= 1'b0;
      link.ubc_irq <= 1'b0;
      link.ext_irq <= 1'b0;
      link.per_irq <= 1'b0;
      link.dbg_reset <= 1'b0;
      link.ext_prio <= 4'h0;
      link.per_prio <= 4'h0;
    end else begin
      link.sleep_exec <= take && avs_write && avs_address == pd_pkg::AV_SLEEP;
      if (take && avs_write && avs_address == pd_pkg::AV_IRQ) begin
        link.nmi <= avs_writedata[0];
        link.dbg_irq <= avs_writedata[1];
        link.ubc_irq <= avs_writedata[2];
        link.ext_irq <= avs_writedata[3];
        link.per_irq <= avs_writedata[4];
        link.dbg_reset <= avs_writedata[5];
        link.ext_prio <= avs_writedata[11:8];
        link.per_prio <= avs_writedata[15:12];
      end else begin
        link.nmi <= 1'b0;
        link.dbg_irq <= 1'b0;
        link.ubc_irq <= 1'b0;
        link.ext_irq <= 1'b0;
        link.per_irq <= 1'b0;
        link.dbg_reset <= 1'b0;
      end
    end
  end

  // Mask level, sense select, watchdog clock select
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      config_word <= pd_pkg::CONFIG_RESET;
    end else if (take && avs_write && avs_address == pd_pkg::AV_CONFIG) begin
      config_word <= avs_writedata;
    end
  end
  assign link.sr_mask = config_word[3:0];
  assign link.ext_sense = config_word[5:4];
  assign link.wdt_cks = config_word[10:8];

  // Sticky wake records, set wins over write-one clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      exc_seen <= 1'b0;
      resume_seen <= 1'b0;
    end else begin
      if (link.exc_start) begin
        exc_seen <= 1'b1;
      end else if (take && avs_write && avs_address == pd_pkg::AV_STATUS &&
          avs_writedata[8]) begin
        exc_seen <= 1'b0;
      end
      if (link.resume) begin
        resume_seen <= 1'b1;
      end else if (take && avs_write && avs_address == pd_pkg::AV_STATUS &&
          avs_writedata[9]) begin
        resume_seen <= 1'b0;
      end
    end
  end

  // Read data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (seen && avs_read) begin
      unique case (avs_address)
        pd_pkg::AV_REG_READ: avs_readdata <= {24'h00_0000, link.reg_rdata};
        pd_pkg::AV_CONFIG: avs_readdata <= config_word;
        pd_pkg::AV_STATUS: avs_readdata <= {22'h00_0000, resume_seen, exc_seen, 3'h0,
            link.cpu_run, 1'b0, link.mode};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : cpu_side_agent

// *** rtl/power_down_mode_controller.sv ***
// Functional notes
// (RL1) Stop-A bit 4 gates the timer
// (RL2) Stop-A bits 2..0 gate serial 2..0
// (RL3) Stop-B bit 4 gates host interface
// (RL4) Stop-B bit 0 gates redundancy logic
// (RL5) Reserved bits read zero, written zero
// (RL6) Sleep with select clear enters sleep
// (RL7) Sleep keeps peripherals and clock output
// (RL8) NMI, debug, break, external, peripheral wake
// (RL9) Masked interrupts never end sleep
// (RL10) Debug reset or power-on ends sleep
// (RL11) Sleep with select set enters standby
// (RL12) Standby retains CPU and cache state
// (RL13) Standby entry initialises timer registers
// (RL14) Software stops and primes watchdog first
// (RL15) Wake waits for watchdog settling time
// (RL16) Select left set re-enters locked standby
// (RL17) Low-level external sense cannot wake standby
// (RL18) Low-priority external wake resumes inline
// (RL19) Power-on ends standby, clock out runs
// (RL20) Stop bits gate clocks in normal run
// (RL21) Clearing bit or reset restarts module
// (RL22) Select is first register bit 7
// (RL23) Second register gates debug, break, cache, memory
// (RL24) Clock enables switch glitch-free
module power_down_mode_controller #(
  parameter int PRESCALE_WIDTH = pd_pkg::PRESCALE_WIDTH_DEF
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Link to the CPU side
  pd_link_if.dev link,
  // Clock gating
  output logic [pd_pkg::NUM_MODULES-1:0] module_clk_en,
  output logic clk_out_en,
  output logic timer_init
);
  generate
    if (PRESCALE_WIDTH < 8) begin : g_bad_width
      $error("PRESCALE_WIDTH must be at least 8");
    end
  endgenerate

  logic [7:0] standby_control_first;
  logic [7:0] standby_control_second;
  logic [7:0] peripheral_clock_stop_a;
  logic [7:0] peripheral_clock_stop_b;
  pd_pkg::mode_e mode;
  pd_pkg::mode_e next_mode;
  logic standby_select;
  logic ext_accept;
  logic per_accept;
  logic sleep_wake;
  logic ext_wake_ok;
  logic standby_wake;
  logic ext_low_prio;
  logic settled;
  logic wdt_running;
  logic wdt_tick;
  logic [7:0] wdt_count;
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic [PRESCALE_WIDTH-1:0] tick_mask;
  logic [pd_pkg::NUM_MODULES-1:0] stop_vec;
  logic periph_on;

  assign link.mode = mode;
  // (RL22) select bit position
  assign standby_select = standby_control_first[pd_pkg::STANDBY_SELECT_BIT];

  // (RL9) mask level check
  assign ext_accept = link.ext_irq && (link.ext_prio > link.sr_mask);
  assign per_accept = link.per_irq && (link.per_prio > link.sr_mask);
  // (RL8) sleep wake sources
  assign sleep_wake = link.nmi || link.dbg_irq || link.ubc_irq || ext_accept || per_accept;
  // (RL17) low-level sense excluded
  assign ext_wake_ok = link.ext_irq && (link.ext_sense != pd_pkg::SENSE_LOW_LEVEL);
  assign standby_wake = link.nmi || ext_wake_ok;

  // (RL5) reserved bits masked on write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      standby_control_first <= pd_pkg::FIRST_RESET;
      standby_control_second <= pd_pkg::SECOND_RESET;
      peripheral_clock_stop_a <= pd_pkg::STOP_A_RESET;
      peripheral_clock_stop_b <= pd_pkg::STOP_B_RESET;
    end else if (link.reg_wr) begin
      unique case (link.reg_addr)
        pd_pkg::ADDR_FIRST: standby_control_first <= link.reg_wdata & pd_pkg::FIRST_MASK;
        pd_pkg::ADDR_SECOND: standby_control_second <= link.reg_wdata & pd_pkg::SECOND_MASK;
        pd_pkg::ADDR_STOP_A: peripheral_clock_stop_a <= link.reg_wdata & pd_pkg::STOP_A_MASK;
        pd_pkg::ADDR_STOP_B: peripheral_clock_stop_b <= link.reg_wdata & pd_pkg::STOP_B_MASK;
      endcase
    end
  end

  // Register read-back
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.reg_rdata <= 8'h00;
    end else begin
      unique case (link.reg_addr)
        pd_pkg::ADDR_FIRST: link.reg_rdata <= standby_control_first;
        pd_pkg::ADDR_SECOND: link.reg_rdata <= standby_control_second;
        pd_pkg::ADDR_STOP_A: link.reg_rdata <= peripheral_clock_stop_a;
        pd_pkg::ADDR_STOP_B: link.reg_rdata <= peripheral_clock_stop_b;
      endcase
    end
  end

  // Watchdog prescaler tick
  always_comb begin
    tick_mask = '0;
    for (int i = 0; i < 8; i++) begin
      if (i <= int'(link.wdt_cks)) begin
        tick_mask[i] = 1'b1;
      end
    end
  end
  // (RL16) in run, counter stops once select clears
  assign wdt_running = (mode == pd_pkg::MODE_SETTLE) ||
      (mode == pd_pkg::MODE_RUN && settled && standby_select);
  assign wdt_tick = wdt_running && ((prescale & tick_mask) == tick_mask);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prescale <= '0;
    end else if (!wdt_running) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // (RL14) counter primed at standby entry
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdt_count <= 8'h00;
    end else if (mode == pd_pkg::MODE_STANDBY) begin
      wdt_count <= 8'h00;
    end else if (wdt_tick) begin
      wdt_count <= wdt_count + 8'h01;
    end
  end

  // Post-wake counting window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settled <= 1'b0;
    end else if (mode == pd_pkg::MODE_SETTLE && next_mode == pd_pkg::MODE_RUN) begin
      settled <= 1'b1;
    end else if (!standby_select || mode != pd_pkg::MODE_RUN) begin
      settled <= 1'b0;
    end
  end

  // Mode sequencing
  always_comb begin
    next_mode = mode;
    unique case (mode)
      pd_pkg::MODE_RUN: begin
        // (RL16) re-entry at the rearm count
        if (settled && standby_select && wdt_count == pd_pkg::WDT_REARM) begin
          next_mode = pd_pkg::MODE_LOCKED;
        // (RL11) select set enters standby
        end else if (link.sleep_exec && standby_select) begin
          next_mode = pd_pkg::MODE_STANDBY;
        // (RL6) select clear enters sleep
        end else if (link.sleep_exec) begin
          next_mode = pd_pkg::MODE_SLEEP;
        end
      end
      pd_pkg::MODE_SLEEP: begin
        // (RL10) debug reset wakes too
        if (sleep_wake || link.dbg_reset) begin
          next_mode = pd_pkg::MODE_RUN;
        end
      end
      pd_pkg::MODE_STANDBY: begin
        if (standby_wake) begin
          next_mode = pd_pkg::MODE_SETTLE;
        end
      end
      pd_pkg::MODE_SETTLE: begin
        // (RL15) leave after full settling count
        if (wdt_tick && wdt_count == pd_pkg::WDT_LAST) begin
          next_mode = pd_pkg::MODE_RUN;
        end
      end
      pd_pkg::MODE_LOCKED: begin
        next_mode = pd_pkg::MODE_LOCKED;
      end
      default: begin
        next_mode = pd_pkg::MODE_RUN;
      end
    endcase
  end

  // (RL19) only power-on reset leaves standby otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode <= pd_pkg::MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // (RL18) remember wake priority
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_low_prio <= 1'b0;
    end else if (mode == pd_pkg::MODE_STANDBY && standby_wake) begin
      ext_low_prio <= !link.nmi && !(link.ext_prio > link.sr_mask);
    end
  end

  // Exception and resume pulses
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.exc_start <= 1'b0;
      link.resume <= 1'b0;
    end else begin
      link.exc_start <= (mode == pd_pkg::MODE_SLEEP && sleep_wake) ||
          (mode == pd_pkg::MODE_SETTLE && next_mode == pd_pkg::MODE_RUN && !ext_low_prio);
      // (RL18) inline resume on low priority
      link.resume <= mode == pd_pkg::MODE_SETTLE && next_mode == pd_pkg::MODE_RUN &&
          ext_low_prio;
    end
  end

  // (RL13) timer cleared on standby entry
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer_init <= 1'b0;
    end else begin
      timer_init <= mode == pd_pkg::MODE_RUN && next_mode == pd_pkg::MODE_STANDBY;
    end
  end

  // (RL12) CPU halted, state untouched
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.cpu_run <= 1'b1;
    end else begin
      link.cpu_run <= next_mode == pd_pkg::MODE_RUN;
    end
  end

  // (RL7) clock output runs in sleep
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_out_en <= 1'b1;
    end else begin
      clk_out_en <= next_mode == pd_pkg::MODE_RUN || next_mode == pd_pkg::MODE_SLEEP;
    end
  end

  assign periph_on = next_mode == pd_pkg::MODE_RUN || next_mode == pd_pkg::MODE_SLEEP;

  always_comb begin
    stop_vec = '0;
    // (RL1) timer stop
    stop_vec[pd_pkg::MOD_TIMER] = peripheral_clock_stop_a[pd_pkg::TIMER_STOP_BIT];
    // (RL2) serial channel stops
    stop_vec[pd_pkg::MOD_SERIAL0] = peripheral_clock_stop_a[pd_pkg::SERIAL0_STOP_BIT];
    stop_vec[pd_pkg::MOD_SERIAL1] = peripheral_clock_stop_a[pd_pkg::SERIAL1_STOP_BIT];
    stop_vec[pd_pkg::MOD_SERIAL2] = peripheral_clock_stop_a[pd_pkg::SERIAL2_STOP_BIT];
    // (RL3) host interface stop
    stop_vec[pd_pkg::MOD_HOST_IF] = peripheral_clock_stop_b[pd_pkg::HOST_IF_STOP_BIT];
    // (RL4) redundancy logic stop
    stop_vec[pd_pkg::MOD_REDUNDANCY] = peripheral_clock_stop_b[pd_pkg::REDUNDANCY_STOP_BIT];
    // (RL23) second register stops
    stop_vec[pd_pkg::MOD_DEBUG] = standby_control_second[pd_pkg::DEBUG_STOP_BIT];
    stop_vec[pd_pkg::MOD_BREAK] = standby_control_second[pd_pkg::BREAK_STOP_BIT];
    stop_vec[pd_pkg::MOD_CACHE] = standby_control_second[pd_pkg::CACHE_STOP_BIT];
    stop_vec[pd_pkg::MOD_UMEM] = standby_control_second[pd_pkg::UMEM_STOP_BIT];
  end

  genvar g;
  generate
    for (g = 0; g < pd_pkg::NUM_MODULES; g++) begin : g_gate
      // (RL24) registered enable, no glitches
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          module_clk_en[g] <= 1'b1;
        end else begin
          // (RL20) gate during normal run
          // (RL21) clearing bit restarts module
          module_clk_en[g] <= periph_on && !stop_vec[g];
        end
      end
    end
  endgenerate
endmodule : power_down_mode_controller

// *** bench/pd_asserts.sv ***
module pd_asserts (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Requests from the cpu end
  input wire logic reg_wr,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic sleep_exec,
  input wire logic nmi,
  input wire logic dbg_irq,
  input wire logic ubc_irq,
  input wire logic ext_irq,
  input wire logic per_irq,
  input wire logic [3:0] per_prio,
  input wire logic [3:0] sr_mask,
  input wire logic [1:0] ext_sense,
  input wire logic dbg_reset,
  // Controller answers
  input wire logic [7:0] reg_rdata,
  input wire pd_pkg::mode_e mode,
  input wire logic cpu_run,
  input wire logic exc_start,
  input wire logic [pd_pkg::NUM_MODULES-1:0] module_clk_en,
  input wire logic clk_out_en,
  input wire logic timer_init
);
  localparam logic [31:0] MASKS = {pd_pkg::STOP_B_MASK, pd_pkg::STOP_A_MASK,
    pd_pkg::SECOND_MASK, pd_pkg::FIRST_MASK};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic [7:0] sh [4];
  logic [pd_pkg::NUM_MODULES-1:0] en_exp;
  logic wake;
  // Shadow of the four registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sh <= '{default: 8'h00};
    end else if (reg_wr) begin
      sh[reg_addr] <= reg_wdata;
    end
  end
  always_comb begin
    en_exp = '1;
    en_exp[pd_pkg::MOD_TIMER] = ~sh[2][pd_pkg::TIMER_STOP_BIT];
    en_exp[pd_pkg::MOD_SERIAL0] = ~sh[2][pd_pkg::SERIAL0_STOP_BIT];
    en_exp[pd_pkg::MOD_SERIAL1] = ~sh[2][pd_pkg::SERIAL1_STOP_BIT];
    en_exp[pd_pkg::MOD_SERIAL2] = ~sh[2][pd_pkg::SERIAL2_STOP_BIT];
    en_exp[pd_pkg::MOD_HOST_IF] = ~sh[3][pd_pkg::HOST_IF_STOP_BIT];
    en_exp[pd_pkg::MOD_REDUNDANCY] = ~sh[3][pd_pkg::REDUNDANCY_STOP_BIT];
    en_exp[pd_pkg::MOD_DEBUG] = ~sh[1][pd_pkg::DEBUG_STOP_BIT];
    en_exp[pd_pkg::MOD_BREAK] = ~sh[1][pd_pkg::BREAK_STOP_BIT];
    en_exp[pd_pkg::MOD_CACHE] = ~sh[1][pd_pkg::CACHE_STOP_BIT];
    en_exp[pd_pkg::MOD_UMEM] = ~sh[1][pd_pkg::UMEM_STOP_BIT];
  end
  assign wake = nmi || dbg_irq || ubc_irq || (per_irq && per_prio > sr_mask);
  function automatic logic [7:0] rsv(input logic [1:0] a);
    return ~MASKS[a*8 +: 8];
  endfunction : rsv

  run_enables_a:
    assert property ((mode == pd_pkg::MODE_RUN || mode == pd_pkg::MODE_SLEEP)
      && mode == $past(mode) && !$past(reg_wr) && !$past(reg_wr, 2)
      |-> module_clk_en == en_exp && clk_out_en)
    else $error("module clocks do not follow stop bits");
  standby_halt_a:
    assert property (mode == pd_pkg::MODE_STANDBY |-> !clk_out_en && module_clk_en == '0 && !cpu_run)
    else $error("clocks still running in standby");
  sleep_entry_a:
    assert property (mode == pd_pkg::MODE_RUN && sleep_exec && !sh[0][pd_pkg::STANDBY_SELECT_BIT]
      |=> mode == pd_pkg::MODE_SLEEP && !cpu_run)
    else $error("sleep not entered");
  standby_entry_a:
    assert property (mode == pd_pkg::MODE_RUN && sleep_exec && sh[0][pd_pkg::STANDBY_SELECT_BIT]
      |=> mode == pd_pkg::MODE_STANDBY && timer_init ##1 !timer_init)
    else $error("standby entry wrong");
  masked_irq_a:
    assert property (mode == pd_pkg::MODE_SLEEP && !wake && !ext_irq && !dbg_reset
      |=> mode == pd_pkg::MODE_SLEEP)
    else $error("sleep left without a wake source");
  sleep_wake_a:
    assert property (mode == pd_pkg::MODE_SLEEP && wake
      |=> mode == pd_pkg::MODE_RUN && cpu_run && exc_start)
    else $error("sleep wake wrong");
  debug_reset_a:
    assert property (mode == pd_pkg::MODE_SLEEP && dbg_reset |=> mode == pd_pkg::MODE_RUN && cpu_run)
    else $error("debug reset did not end sleep");
  standby_hold_a:
    assert property (mode == pd_pkg::MODE_STANDBY && !nmi
      && !(ext_irq && ext_sense != pd_pkg::SENSE_LOW_LEVEL) |=> mode == pd_pkg::MODE_STANDBY)
    else $error("standby left without a wake source");
  standby_wake_a:
    assert property (mode == pd_pkg::MODE_STANDBY && nmi |=> mode == pd_pkg::MODE_SETTLE [*8])
    else $error("standby wake skipped settling");
  locked_hold_a:
    assert property (mode == pd_pkg::MODE_LOCKED |=> mode == pd_pkg::MODE_LOCKED)
    else $error("locked standby left without reset");
  reserved_zero_a:
    assert property ((reg_rdata & rsv($past(reg_addr))) == 8'h00)
    else $error("reserved bits read as one");
endmodule : pd_asserts

// *** bench/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] a;
    logic [31:0] m;
    logic [31:0] e;
  } note_s;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [pd_pkg::NUM_MODULES-1:0] module_clk_en;
  logic clk_out_en;
  logic timer_init;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 43;
  note_s q[$];
  logic [7:0] msk [4] = '{pd_pkg::FIRST_MASK, pd_pkg::SECOND_MASK, pd_pkg::STOP_A_MASK,
    pd_pkg::STOP_B_MASK};
  logic [7:0] rnd;

  pd_link_if link ();
  cpu_side_agent cpu_side_agent_i (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
  power_down_mode_controller #(.PRESCALE_WIDTH(12)) power_down_mode_controller_i (
    .clk_sys(clk_sys), .rst(rst), .link(link), .module_clk_en(module_clk_en),
    .clk_out_en(clk_out_en), .timer_init(timer_init));
  pd_asserts pd_asserts_i (.clk_sys(clk_sys), .rst(rst), .reg_wr(link.reg_wr),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .sleep_exec(link.sleep_exec),
    .nmi(link.nmi), .dbg_irq(link.dbg_irq), .ubc_irq(link.ubc_irq), .ext_irq(link.ext_irq),
    .per_irq(link.per_irq), .per_prio(link.per_prio), .sr_mask(link.sr_mask),
    .ext_sense(link.ext_sense), .dbg_reset(link.dbg_reset), .reg_rdata(link.reg_rdata),
    .mode(link.mode), .cpu_run(link.cpu_run), .exc_start(link.exc_start),
    .module_clk_en(module_clk_en), .clk_out_en(clk_out_en), .timer_init(timer_init));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      $display("mismatch waitrequest at %h expected 0 seen %b", a, avs_waitrequest);
      n_mismatch++;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{a, m, e});
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  task automatic regw(input logic [1:0] i, input logic [7:0] d);
    xfer(pd_pkg::AV_REG_WRITE, 1'b1, {22'h0, i, d});
  endtask : regw

  task automatic regr(input logic [1:0] i, input logic [7:0] e);
    xfer(pd_pkg::AV_REG_READ, 1'b1, {22'h0, i, 8'h00});
    repeat (3) @(posedge clk_sys);
    rd(pd_pkg::AV_REG_READ, {24'h0, e}, 32'h0000_00ff);
  endtask : regr

  task automatic mst(input pd_pkg::mode_e md, input logic run);
    rd(pd_pkg::AV_STATUS, {27'h0, run, 1'b0, md}, 32'h0000_0017);
  endtask : mst

  task automatic irq(input logic [5:0] b, input logic [3:0] ep, input logic [3:0] pp);
    xfer(pd_pkg::AV_IRQ, 1'b1, {16'h0, pp, ep, 2'b00, b});
  endtask : irq

  task automatic cfg(input logic [3:0] m, input logic [1:0] s);
    xfer(pd_pkg::AV_CONFIG, 1'b1, {21'h0, 3'h0, 2'b00, s, m});
  endtask : cfg

  always @(posedge clk_sys) begin : monitor
    note_s n;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      n = '{5'h1f, 32'hffff_ffff, 32'hxxxx_xxxx};
      if (q.size() > 0) begin
        n = q.pop_front();
      end
      n_compared++;
      if (((avs_readdata ^ n.e) & n.m) !== 32'h0) begin
        $display("mismatch readdata at %h expected %h seen %h", n.a, n.e, avs_readdata & n.m);
        n_mismatch++;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    $display("mismatch watchdog expected end seen hang");
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    mst(pd_pkg::MODE_RUN, 1'b1);
    regw(pd_pkg::ADDR_STOP_B, 8'h01);
    for (int i = 0; i < 4; i++) begin
      regr(i[1:0], (i == 3) ? 8'h01 : 8'h00);
      rnd = 8'($random(seed));
      regw(i[1:0], rnd);
      regr(i[1:0], rnd & msk[i]);
      regw(i[1:0], 8'hff);
      regr(i[1:0], msk[i]);
      regw(i[1:0], 8'h00);
      regr(i[1:0], 8'h00);
    end
    $display("test registers done");
    cfg(4'h8, 2'h0);
    regw(pd_pkg::ADDR_STOP_A, 8'h05);
    for (int j = 0; j < 6; j++) begin
      xfer(pd_pkg::AV_SLEEP, 1'b1, 32'h0);
      mst(pd_pkg::MODE_SLEEP, 1'b0);
      if (j == 0) begin
        irq(6'h10, 4'h0, 4'h8);
        irq(6'h08, 4'h8, 4'h0);
        mst(pd_pkg::MODE_SLEEP, 1'b0);
      end
      irq(6'h01 << j, 4'h9, 4'h9);
      mst(pd_pkg::MODE_RUN, 1'b1);
      rd(pd_pkg::AV_STATUS, (j < 5) ? 32'h100 : 32'h0, 32'h100);
      xfer(pd_pkg::AV_STATUS, 1'b1, 32'h300);
    end
    $display("test sleep done");
    regw(pd_pkg::ADDR_STOP_A, 8'h17);
    regw(pd_pkg::ADDR_FIRST, 8'h80);
    xfer(pd_pkg::AV_SLEEP, 1'b1, 32'h0);
    mst(pd_pkg::MODE_STANDBY, 1'b0);
    irq(6'h18, 4'h9, 4'h9);
    mst(pd_pkg::MODE_STANDBY, 1'b0);
    irq(6'h01, 4'h0, 4'h0);
    repeat (400) @(posedge clk_sys);
    mst(pd_pkg::MODE_SETTLE, 1'b0);
    repeat (200) @(posedge clk_sys);
    mst(pd_pkg::MODE_RUN, 1'b1);
    rd(pd_pkg::AV_STATUS, 32'h100, 32'h300);
    regr(pd_pkg::ADDR_STOP_A, 8'h17);
    repeat (300) @(posedge clk_sys);
    mst(pd_pkg::MODE_LOCKED, 1'b0);
    irq(6'h01, 4'h0, 4'h0);
    mst(pd_pkg::MODE_LOCKED, 1'b0);
    rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    mst(pd_pkg::MODE_RUN, 1'b1);
    regr(pd_pkg::ADDR_STOP_A, 8'h00);
    $display("test standby done");
    cfg(4'h8, 2'h1);
    regw(pd_pkg::ADDR_FIRST, 8'h80);
    xfer(pd_pkg::AV_SLEEP, 1'b1, 32'h0);
    irq(6'h08, 4'h3, 4'h0);
    mst(pd_pkg::MODE_SETTLE, 1'b0);
    repeat (600) @(posedge clk_sys);
    rd(pd_pkg::AV_STATUS, 32'h210, 32'h317);
    regw(pd_pkg::ADDR_FIRST, 8'h00);
    repeat (400) @(posedge clk_sys);
    mst(pd_pkg::MODE_RUN, 1'b1);
    $display("test external wake done");
    finish_test();
  end
endmodule : tb_top
